// ==== rtl/plt_regs.sv ====
// lock, tuning calibration and peak remover register group
// assumes host access arrives as synchronous strobes from the serial port decoder,
// and analogue status inputs are asynchronous
`timescale 1ns/1ps
// Overview of operation
// - pin select resets 0000 pump output; codes 1-5 route lock, alarm, done flags
// - codes 6,7,9,D,E,F route IF, dividers, violation, hold, comparator; B,C undefined
// - code 8 routes transmit-active, high when transmitter not powered down
// - code A routes receive-active, high when receiver not powered down
// - precision bit clear: lock at 127, release at 111
// - precision bit set: lock at 31, release at 15
// - momentary and sustained lock flags read in bits 1 and 0
// - rising edge written to start bit begins calibration
// - store-both writes A and B; else set chosen by set-select
// - wait about 14 ms at 2 MHz reference; half-wait bit halves it
// - calibration current bit doubles the calibration current
// - done flag set at end of run, resets to zero, readable
// - peak remover enable resets 1; zero bypasses peak remover
// - seven-bit peak threshold resets 0010110, drives peak remover level
// - alarm flags show tuning voltage near supply or ground
module plt_regs
#(
  parameter int CAL_WAIT_REFS = plt_pkg::CAL_WAIT_REFS
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic       set_select_i,
  input  wire logic       ref_tick_i,
  input  wire logic       cmp_tick_i,
  input  wire logic       phase_ok_i,
  input  wire logic       alarm_hi_i,
  input  wire logic       alarm_lo_i,
  input  wire logic       pump_i,
  input  wire logic       if_out_i,
  input  wire logic       ref_div_i,
  input  wire logic       fb_div_i,
  input  wire logic       violation_i,
  input  wire logic       avg_hold_i,
  input  wire logic       transmit_powerdown_i,
  input  wire logic       receive_powerdown_i,
  output logic            pump_output_pin_o,
  output logic            cal_busy_o,
  output logic            cal_store_a_o,
  output logic            cal_store_b_o,
  output logic            cal_double_cur_o,
  output logic      [2:0] tuning_dac_start_value_o,
  output logic            peak_remover_enable_o,
  output logic      [6:0] peak_level_o
);
  typedef enum {PLT_IDLE, PLT_WAIT, PLT_DONE} plt_cal_t;

  logic [3:0]  pin_sel;
  logic        det_prec;
  logic        det_window;
  logic        tune_start;
  logic        store_both;
  logic        half_wait;
  logic        cal_cur;
  logic        tuning_done;
  logic [2:0]  dac_start;
  logic        peak_en;
  logic [6:0]  peak_lvl;
  logic [2:0]  sync_hi;
  logic [2:0]  sync_lo;
  logic [2:0]  sync_ph;
  logic        alarm_hi;
  logic        alarm_lo;
  logic        phase_ok;
  logic        momentary;
  logic        sustained;
  logic [31:0] wait_cnt;
  logic [31:0] wait_len;
  logic        start_edge;
  plt_cal_t    cal_state;
  logic        next_pin;
  logic [7:0]  next_rdata;

  // three-stage sync; change accepted when stages two and three agree
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_hi <= 3'h0;
      sync_lo <= 3'h0;
      sync_ph <= 3'h0;
    end
    else
    begin
      sync_hi <= {sync_hi[1:0], alarm_hi_i};
      sync_lo <= {sync_lo[1:0], alarm_lo_i};
      sync_ph <= {sync_ph[1:0], phase_ok_i};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      alarm_hi <= 1'b0;
      alarm_lo <= 1'b0;
      phase_ok <= 1'b0;
    end
    else
    begin
      if (sync_hi[1] == sync_hi[2])
        alarm_hi <= sync_hi[2];
      if (sync_lo[1] == sync_lo[2])
        alarm_lo <= sync_lo[2];
      if (sync_ph[1] == sync_ph[2])
        phase_ok <= sync_ph[2];
    end
  end

  plt_lock_det u_lock_det
  (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .coarse_i    (det_prec),
    .cmp_tick_i  (cmp_tick_i),
    .phase_ok_i  (phase_ok),
    .momentary_o (momentary),
    .sustained_o (sustained)
  );

  // detector control register; status bits are not stored
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_sel    <= plt_pkg::PIN_SEL_RST;
      det_prec   <= plt_pkg::DET_PREC_RST;
      det_window <= plt_pkg::DET_WIN_RST;
    end
    else if (wr_i && addr_i == plt_pkg::DET_CTRL_ADDR)
    begin
      pin_sel    <= wdata_i[plt_pkg::PIN_SEL_LSB +: 4];
      det_prec   <= wdata_i[plt_pkg::DET_PREC_BIT];
      det_window <= wdata_i[plt_pkg::DET_WINDOW_BIT];
    end
  end

  // tuning control register; done bit is hardware owned
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tune_start <= 1'b0;
      store_both <= 1'b0;
      half_wait  <= 1'b0;
      cal_cur    <= 1'b0;
      dac_start  <= plt_pkg::DAC_START_RST;
    end
    else if (wr_i && addr_i == plt_pkg::TUNE_CTRL_ADDR)
    begin
      tune_start <= wdata_i[plt_pkg::TUNE_START_BIT];
      store_both <= wdata_i[plt_pkg::STORE_BOTH_BIT];
      half_wait  <= wdata_i[plt_pkg::HALF_WAIT_BIT];
      cal_cur    <= wdata_i[plt_pkg::CAL_CUR_BIT];
      dac_start  <= wdata_i[plt_pkg::DAC_START_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      peak_en  <= plt_pkg::PEAK_EN_RST;
      peak_lvl <= plt_pkg::PEAK_LVL_RST;
    end
    else if (wr_i && addr_i == plt_pkg::PEAK_CTRL_ADDR)
    begin
      peak_en  <= wdata_i[plt_pkg::PEAK_EN_BIT];
      peak_lvl <= wdata_i[plt_pkg::PEAK_LVL_LSB +: 7];
    end
  end

  // rising edge of the written start bit only
  assign start_edge = wr_i && addr_i == plt_pkg::TUNE_CTRL_ADDR
                      && wdata_i[plt_pkg::TUNE_START_BIT] && !tune_start;
  assign wait_len   = half_wait ? (CAL_WAIT_REFS / 2) : CAL_WAIT_REFS;

  // calibration sequencer, waiting in reference periods
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cal_state   <= PLT_IDLE;
      wait_cnt    <= 32'h0;
      tuning_done <= 1'b0;
    end
    else
    begin
      case (cal_state)
        PLT_IDLE:
          if (start_edge)
          begin
            cal_state   <= PLT_WAIT;
            wait_cnt    <= 32'h0;
            tuning_done <= 1'b0;
          end
        PLT_WAIT:
          if (ref_tick_i)
          begin
            if (wait_cnt + 32'h1 >= wait_len)
            begin
              cal_state   <= PLT_DONE;
              tuning_done <= 1'b1;
            end
            else
              wait_cnt <= wait_cnt + 32'h1;
          end
        PLT_DONE:
          if (!tune_start)
            cal_state <= PLT_IDLE;
        default:
          cal_state <= PLT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cal_busy_o       <= 1'b0;
      cal_store_a_o    <= 1'b0;
      cal_store_b_o    <= 1'b0;
      cal_double_cur_o <= 1'b0;
    end
    else
    begin
      cal_busy_o       <= cal_state == PLT_WAIT;
      cal_double_cur_o <= cal_state == PLT_WAIT && cal_cur;
      // one-cycle store strobe at completion
      cal_store_a_o    <= cal_state == PLT_WAIT && ref_tick_i && wait_cnt + 32'h1 >= wait_len
                          && (store_both || !set_select_i);
      cal_store_b_o    <= cal_state == PLT_WAIT && ref_tick_i && wait_cnt + 32'h1 >= wait_len
                          && (store_both || set_select_i);
    end
  end

  // output pin source multiplexer
  always_comb
  begin
    case (pin_sel)
      plt_pkg::SEL_PUMP:      next_pin = pump_i;
      plt_pkg::SEL_SUSTAINED: next_pin = sustained;
      plt_pkg::SEL_MOMENTARY: next_pin = momentary;
      plt_pkg::SEL_ALARM_HI:  next_pin = alarm_hi;
      plt_pkg::SEL_ALARM_LO:  next_pin = alarm_lo;
      plt_pkg::SEL_DONE:      next_pin = tuning_done;
      plt_pkg::SEL_IF_OUT:    next_pin = if_out_i;
      plt_pkg::SEL_REF_DIV:   next_pin = ref_div_i;
      plt_pkg::SEL_TX_ACT:    next_pin = !transmit_powerdown_i;
      plt_pkg::SEL_VIOLATION: next_pin = violation_i;
      plt_pkg::SEL_RX_ACT:    next_pin = !receive_powerdown_i;
      plt_pkg::SEL_AVG_HOLD:  next_pin = avg_hold_i;
      plt_pkg::SEL_FB_DIV:    next_pin = fb_div_i;
      plt_pkg::SEL_PHASE_CMP: next_pin = phase_ok;
      default:                next_pin = 1'b0;
    endcase
  end

  // read mux; status bits come from live state
  always_comb
  begin
    case (addr_i)
      plt_pkg::DET_CTRL_ADDR:  next_rdata = {pin_sel, det_prec, det_window, momentary, sustained};
      plt_pkg::TUNE_CTRL_ADDR: next_rdata = {tune_start, store_both, half_wait, cal_cur, tuning_done,
                                             dac_start};
      plt_pkg::PEAK_CTRL_ADDR: next_rdata = {peak_en, peak_lvl};
      default:                 next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pump_output_pin_o        <= 1'b0;
      rdata_o                  <= 8'h00;
      tuning_dac_start_value_o <= plt_pkg::DAC_START_RST;
      peak_remover_enable_o    <= plt_pkg::PEAK_EN_RST;
      peak_level_o             <= plt_pkg::PEAK_LVL_RST;
    end
    else
    begin
      pump_output_pin_o        <= next_pin;
      rdata_o                  <= next_rdata;
      tuning_dac_start_value_o <= dac_start;
      peak_remover_enable_o    <= peak_en;
      peak_level_o             <= peak_lvl;
    end
  end
endmodule

// ==== rtl/plt_pkg.sv ====
// constants for the lock/tuning/peak register group
// assumes a 125 MHz system clock and 8-bit register data
package plt_pkg;
  localparam logic [6:0] DET_CTRL_ADDR  = 7'h0D;
  localparam logic [6:0] TUNE_CTRL_ADDR = 7'h0E;
  localparam logic [6:0] PEAK_CTRL_ADDR = 7'h0F;

  // detector control field positions
  localparam int PIN_SEL_LSB     = 4;
  localparam int DET_PREC_BIT    = 3;
  localparam int DET_WINDOW_BIT  = 2;
  localparam int MOMENTARY_BIT   = 1;
  localparam int SUSTAINED_BIT   = 0;
  // tuning control field positions
  localparam int TUNE_START_BIT  = 7;
  localparam int STORE_BOTH_BIT  = 6;
  localparam int HALF_WAIT_BIT   = 5;
  localparam int CAL_CUR_BIT     = 4;
  localparam int TUNE_DONE_BIT   = 3;
  localparam int DAC_START_LSB   = 0;
  // peak control field positions
  localparam int PEAK_EN_BIT     = 7;
  localparam int PEAK_LVL_LSB    = 0;

  // reset values
  localparam logic [3:0] PIN_SEL_RST   = 4'h0;
  localparam logic       DET_PREC_RST  = 1'b0;
  localparam logic       DET_WIN_RST   = 1'b0;
  localparam logic [2:0] DAC_START_RST = 3'h5;
  localparam logic       PEAK_EN_RST   = 1'b1;
  localparam logic [6:0] PEAK_LVL_RST  = 7'h16;

  // lock detector thresholds
  localparam logic [7:0] LOCK_SET_FINE    = 8'h7F;
  localparam logic [7:0] LOCK_CLR_FINE    = 8'h6F;
  localparam logic [7:0] LOCK_SET_COARSE  = 8'h1F;
  localparam logic [7:0] LOCK_CLR_COARSE  = 8'h0F;

  // pin source codes
  localparam logic [3:0] SEL_PUMP      = 4'h0;
  localparam logic [3:0] SEL_SUSTAINED = 4'h1;
  localparam logic [3:0] SEL_MOMENTARY = 4'h2;
  localparam logic [3:0] SEL_ALARM_HI  = 4'h3;
  localparam logic [3:0] SEL_ALARM_LO  = 4'h4;
  localparam logic [3:0] SEL_DONE      = 4'h5;
  localparam logic [3:0] SEL_IF_OUT    = 4'h6;
  localparam logic [3:0] SEL_REF_DIV   = 4'h7;
  localparam logic [3:0] SEL_TX_ACT    = 4'h8;
  localparam logic [3:0] SEL_VIOLATION = 4'h9;
  localparam logic [3:0] SEL_RX_ACT    = 4'hA;
  localparam logic [3:0] SEL_AVG_HOLD  = 4'hD;
  localparam logic [3:0] SEL_FB_DIV    = 4'hE;
  localparam logic [3:0] SEL_PHASE_CMP = 4'hF;

  // calibration wait: 14 ms at 2 MHz reference = 28000 reference periods
  localparam int  CLK_HZ          = 125_000_000;
  localparam int  CAL_WAIT_MS     = 14;
  localparam int  CAL_REF_HZ      = 2_000_000;
  localparam int  CAL_WAIT_REFS   = CAL_WAIT_MS * (CAL_REF_HZ / 1000);
endpackage

// ==== rtl/plt_lock_det.sv ====
// lock detector with hysteresis on a count of in-window comparisons
// assumes phase_ok_i and cmp_tick_i are synchronous to clk_sys_i
`timescale 1ns/1ps
module plt_lock_det
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic coarse_i,
  input  wire logic cmp_tick_i,
  input  wire logic phase_ok_i,
  output logic      momentary_o,
  output logic      sustained_o
);
  logic [7:0] good_cnt;
  logic [7:0] next_cnt;
  logic [7:0] set_lvl;
  logic [7:0] clr_lvl;

  assign set_lvl = coarse_i ? plt_pkg::LOCK_SET_COARSE : plt_pkg::LOCK_SET_FINE;
  assign clr_lvl = coarse_i ? plt_pkg::LOCK_CLR_COARSE : plt_pkg::LOCK_CLR_FINE;

  // count consecutive good comparisons, saturating at set level
  always_comb
  begin
    next_cnt = good_cnt;
    if (cmp_tick_i)
    begin
      if (!phase_ok_i)
        next_cnt = 8'h00;
      else if (good_cnt < set_lvl)
        next_cnt = good_cnt + 8'h01;
      else
        next_cnt = set_lvl;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      good_cnt <= 8'h00;
    else
      good_cnt <= next_cnt;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      momentary_o <= 1'b0;
    else if (cmp_tick_i)
      momentary_o <= phase_ok_i;
  end

  // declare at set level, release once the count falls to clear level
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      sustained_o <= 1'b0;
    else if (next_cnt >= set_lvl)
      sustained_o <= 1'b1;
    else if (cmp_tick_i && next_cnt <= clr_lvl)
      sustained_o <= 1'b0;
  end
endmodule

// ==== sim/plt_regs_monitor.sv ====
// checker for the lock, tuning and peak register group
// assumes one clock domain and single-cycle host write strobes
`timescale 1ns/1ps
module plt_regs_monitor
#(
  parameter int CAL_WAIT_REFS = 8
)
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       wr_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       set_select_i,
  input wire logic       ref_tick_i,
  input wire logic       pump_i,
  input wire logic       transmit_powerdown_i,
  input wire logic       receive_powerdown_i,
  input wire logic       pump_output_pin_o,
  input wire logic       cal_busy_o,
  input wire logic       cal_store_a_o,
  input wire logic       cal_store_b_o,
  input wire logic       cal_double_cur_o,
  input wire logic [2:0] tuning_dac_start_value_o,
  input wire logic       peak_remover_enable_o,
  input wire logic [6:0] peak_level_o
);
  logic       live;
  logic [3:0] sel;
  logic [7:0] tune;
  logic [7:0] peak;
  logic [7:0] nref;
  logic       run;
  wire        st_wr  = wr_i && addr_i == plt_pkg::TUNE_CTRL_ADDR && wdata_i[7];
  wire        strobe = cal_store_a_o || cal_store_b_o;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // mirror of the host-written fields
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      live <= 1'b0;
      sel  <= 4'h0;
      tune <= 8'h05;
      peak <= 8'h96;
    end
    else
    begin
      live <= 1'b1;
      if (wr_i && addr_i == plt_pkg::DET_CTRL_ADDR)
        sel <= wdata_i[7:4];
      if (wr_i && addr_i == plt_pkg::TUNE_CTRL_ADDR)
        tune <= wdata_i;
      if (wr_i && addr_i == plt_pkg::PEAK_CTRL_ADDR)
        peak <= wdata_i;
    end

  // reference ticks seen from the start write up to the store strobe
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      run  <= 1'b0;
      nref <= 8'h00;
    end
    else if (st_wr && !tune[7] && !cal_busy_o)
    begin
      run  <= 1'b1;
      nref <= 8'h00;
    end
    else if (strobe)
      run <= 1'b0;
    else if (run && ref_tick_i)
      nref <= nref + 8'h01;

  chk_pin_pump: assert property (live && $past(sel) == 4'h0 |-> pump_output_pin_o == $past(pump_i))
    else $error("pin does not follow pump source");
  chk_pin_transmit: assert property (live && $past(sel) == 4'h8 |-> pump_output_pin_o == !$past(transmit_powerdown_i))
    else $error("pin does not show transmit active");
  chk_pin_receive: assert property (live && $past(sel) == 4'hA |-> pump_output_pin_o == !$past(receive_powerdown_i))
    else $error("pin does not show receive active");
  chk_start_busy: assert property (st_wr && !tune[7] && !cal_busy_o |=> ##1 cal_busy_o)
    else $error("start edge did not begin a run");
  chk_busy_idle: assert property (!cal_busy_o && !st_wr && !$past(st_wr) |=> !cal_busy_o)
    else $error("run began without a start edge");
  chk_store_sets: assert property (strobe |-> cal_store_a_o == (tune[6] || !set_select_i) && cal_store_b_o == (tune[6] || set_select_i))
    else $error("result stored to wrong set");
  chk_wait_length: assert property (strobe |-> nref == (tune[5] ? CAL_WAIT_REFS / 2 : CAL_WAIT_REFS))
    else $error("wait length wrong");
  chk_cur_double: assert property ($rose(cal_busy_o) |-> cal_double_cur_o == tune[4])
    else $error("calibration current wrong");
  chk_field_copies: assert property (live && $stable(peak) && $stable(tune) |-> {peak_remover_enable_o, peak_level_o} == peak && tuning_dac_start_value_o == tune[2:0])
    else $error("register copies wrong");

  cover property (strobe && tune[6]);
  cover property (strobe && tune[5]);
  cover property (live && $past(sel) == 4'h8);
endmodule

bind plt_regs plt_regs_monitor #(.CAL_WAIT_REFS(CAL_WAIT_REFS)) plt_regs_monitor_i (.*);

// ==== sim/plt_host.sv ====
// host model: register writes and reads on the strobe port
// assumes read data follows the address one cycle later
`timescale 1ns/1ps
module plt_host
(
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic      [6:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial
  begin
    wr_o    = 1'b0;
    addr_o  = 7'h00;
    wdata_o = 8'h00;
  end

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    wr_o    = 1'b1;
    addr_o  = a;
    wdata_o = (a == plt_pkg::DET_CTRL_ADDR) ? (d & 8'hFB) : d;
    @(posedge clk_sys_i);
    #1;
    wr_o    = 1'b0;
    wdata_o = ~wdata_o;
  endtask

  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    addr_o = a;
    @(posedge clk_sys_i);
    #1;
    d = rdata_i;
  endtask

  // start, poll done, then clear start
  task automatic cal_run(input logic [2:0] opt, output logic [7:0] st);
    int n;
    wr_reg(plt_pkg::TUNE_CTRL_ADDR, {1'b1, opt, 1'b0, 3'h6});
    n  = 0;
    st = 8'h00;
    while (st[plt_pkg::TUNE_DONE_BIT] !== 1'b1 && n < 200)
    begin
      rd_reg(plt_pkg::TUNE_CTRL_ADDR, st);
      n++;
    end
    wr_reg(plt_pkg::TUNE_CTRL_ADDR, {1'b0, opt, 1'b0, 3'h6});
  endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the lock, tuning and peak register group
// assumes plt_host drives the host strobes; the bench drives the rest
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb;
  localparam int WAIT_REFS = 8;
  logic        clk_sys_i  = 1'b0;
  logic        rst_i      = 1'b1;
  logic        set_select = 1'b0;
  logic        cmp_tick   = 1'b0;
  logic [15:0] s          = 16'h0000;
  logic [1:0]  rcnt       = 2'h0;
  logic        seen_a, seen_b, seen_cur;
  logic        wr, pin, busy, sa, sb, dcur, pen;
  logic [6:0]  addr, plvl;
  logic [7:0]  wdata, rdata;
  logic [2:0]  dac;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;

  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) rcnt <= #1 rcnt + 2'h1;

  plt_host host_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

  // source vector indexed by pin select code
  plt_regs #(.CAL_WAIT_REFS(WAIT_REFS)) plt_regs_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .set_select_i(set_select), .ref_tick_i(rcnt == 2'h3), .cmp_tick_i(cmp_tick), .phase_ok_i(s[15]),
    .alarm_hi_i(s[3]), .alarm_lo_i(s[4]), .pump_i(s[0]), .if_out_i(s[6]), .ref_div_i(s[7]),
    .fb_div_i(s[14]), .violation_i(s[9]), .avg_hold_i(s[13]), .transmit_powerdown_i(!s[8]),
    .receive_powerdown_i(!s[10]), .pump_output_pin_o(pin), .cal_busy_o(busy), .cal_store_a_o(sa),
    .cal_store_b_o(sb), .cal_double_cur_o(dcur), .tuning_dac_start_value_o(dac),
    .peak_remover_enable_o(pen), .peak_level_o(plvl)
  );

  always @(posedge clk_sys_i)
  begin
    if (sa)
      seen_a <= 1'b1;
    if (sb)
      seen_b <= 1'b1;
    if (busy && dcur)
      seen_cur <= 1'b1;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      #1;
      cmp_tick = 1'b1;
      @(posedge clk_sys_i);
      #1;
      cmp_tick = 1'b0;
    end
  endtask

  task automatic t_reset();
    logic [7:0] d;
    host_i.rd_reg(plt_pkg::DET_CTRL_ADDR, d);
    `CHK("det reset", 8'h00, d)
    host_i.rd_reg(plt_pkg::TUNE_CTRL_ADDR, d);
    `CHK("tune reset", 8'h05, d)
    host_i.rd_reg(plt_pkg::PEAK_CTRL_ADDR, d);
    `CHK("peak reset", 8'h96, d)
    `CHK("peak out", 8'h96, {pen, plvl})
    host_i.rd_reg(7'h20, d);
    `CHK("unmapped", 8'h00, d)
    host_i.wr_reg(plt_pkg::TUNE_CTRL_ADDR, 8'h0E);
    host_i.rd_reg(plt_pkg::TUNE_CTRL_ADDR, d);
    `CHK("done write", 8'h06, d)
    host_i.wr_reg(plt_pkg::PEAK_CTRL_ADDR, 8'h2A);
    host_i.rd_reg(plt_pkg::PEAK_CTRL_ADDR, d);
    `CHK("peak rw", 8'h2A, d)
    `CHK("peak out", 8'h2A, {pen, plvl})
  endtask

  // selected source differs from all others
  task automatic t_pin();
    logic [3:0] c;
    for (int i = 0; i < 32; i++)
    begin
      c = i[4:1];
      if (c == 4'h1 || c == 4'h2 || c == 4'h5)
        continue;
      host_i.wr_reg(plt_pkg::DET_CTRL_ADDR, {c, 4'h0});
      s = i[0] ? (16'h0001 << c) : ~(16'h0001 << c);
      repeat (6) @(posedge clk_sys_i);
      #1;
      `CHK("pin", (c == 4'hB || c == 4'hC) ? 1'b0 : i[0], pin)
    end
  endtask

  // fine run shows the sustained flag on the pin, coarse run the momentary one
  task automatic t_lock(input logic prec, input int n);
    logic [7:0] d;
    logic [3:0] sc;
    sc = prec ? 4'h2 : 4'h1;
    host_i.wr_reg(plt_pkg::DET_CTRL_ADDR, {sc, prec, 3'h3});
    host_i.rd_reg(plt_pkg::DET_CTRL_ADDR, d);
    `CHK("det bits", {sc, prec, 3'h0}, d)
    s[15] = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    tick(n - 1);
    host_i.rd_reg(plt_pkg::DET_CTRL_ADDR, d);
    `CHK("below lock", 2'h2, d[1:0])
    tick(1);
    host_i.rd_reg(plt_pkg::DET_CTRL_ADDR, d);
    `CHK("locked", 2'h3, d[1:0])
    `CHK("pin lock", 1'b1, pin)
    s[15] = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    tick(1);
    host_i.rd_reg(plt_pkg::DET_CTRL_ADDR, d);
    `CHK("released", 2'h0, d[1:0])
  endtask

  // opt holds dual, half wait, double current
  task automatic t_cal(input logic [2:0] opt, input logic ssel);
    logic [7:0] d;
    set_select = ssel;
    seen_a     = 1'b0;
    seen_b     = 1'b0;
    seen_cur   = 1'b0;
    host_i.cal_run(opt, d);
    `CHK("done", 1'b1, d[3])
    `CHK("store a", opt[2] | !ssel, seen_a)
    `CHK("store b", opt[2] | ssel, seen_b)
    `CHK("double cur", opt[0], seen_cur)
    `CHK("dac out", 3'h6, dac)
    host_i.rd_reg(plt_pkg::TUNE_CTRL_ADDR, d);
    `CHK("after clear", {1'b0, opt, 1'b1, 3'h6}, d)
    host_i.wr_reg(plt_pkg::DET_CTRL_ADDR, {4'h5, 4'h0});
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("pin done", 1'b1, pin)
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_pin();
    t_lock(1'b0, 127);
    t_lock(1'b1, 31);
    t_cal(3'h4, 1'b0);
    t_cal(3'h2, 1'b0);
    t_cal(3'h1, 1'b1);
    close_out();
  end
endmodule
